// *** include/dst_timer_defines.svh ***
// Purpose: Offsets, field positions, reset values and codes for the dual 6-bit down timers
// Assumes: Included by its bare name from the package and the design files
// Notes:   Byte offsets on a 32-bit Avalon-MM slave, one register per aligned word
`ifndef DST_TIMER_DEFINES_SVH
`define DST_TIMER_DEFINES_SVH

// Register byte offsets
`define DST_OFF_LOAD_ONE     6'h00
`define DST_OFF_LOAD_TWO     6'h04
`define DST_OFF_FLAG_SET     6'h08
`define DST_OFF_FLAG_CLR     6'h0C
`define DST_OFF_CONTROL      6'h10
`define DST_OFF_CLEAR_REQ    6'h14
`define DST_OFF_STATUS_ONE   6'h18
`define DST_OFF_STATUS_TWO   6'h1C

// Load word fields
`define DST_LOAD_SEL_MSB     8
`define DST_LOAD_SEL_LSB     6
`define DST_LOAD_VAL_MSB     5
`define DST_LOAD_REGFORM_BIT 16

// Flag set and clear bits
`define DST_FLAG_RELOAD_ONE  0
`define DST_FLAG_RELOAD_TWO  1
`define DST_FLAG_KEEP_GATE   2

// Control register bits
`define DST_CTL_IRQ_EN_ONE   0
`define DST_CTL_IRQ_EN_FOUR  1
`define DST_CTL_WAKE_EN_ONE  2
`define DST_CTL_WAKE_EN_FOUR 3
`define DST_CTL_CONV_MODE    4

// Clock select codes and reset values
`define DST_SEL_TAP_9        3'h0
`define DST_SEL_TAP_3        3'h1
`define DST_SEL_TAP_15       3'h2
`define DST_SEL_AUX          3'h3
`define DST_SEL_TAP_5        3'h4
`define DST_SEL_TAP_7        3'h5
`define DST_SEL_TAP_11       3'h6
`define DST_SEL_TAP_13       3'h7
`define DST_RST_SEL_ONE      `DST_SEL_TAP_3
`define DST_RST_SEL_TWO      `DST_SEL_TAP_7
`define DST_COUNT_TOP        6'h3F

`endif

// *** include/dst_pkg.sv ***
// Purpose: Types shared by the dual down timer design
// Assumes: Constants come from the defines header
// Notes:   Packed structs carry the load word and the per-timer status
`include "dst_timer_defines.svh"
package dst_pkg;

	// Bus answer sequencer
	typedef enum logic { DST_BUS_IDLE, DST_BUS_ANSWER } dst_bus_state_type;

	// Decoded load word
	typedef struct packed {
		logic [2:0] clk_sel;   // Clock source code
		logic [5:0] start;     // Start value
	} dst_load_type;

	// Per-timer status as seen by software
	typedef struct packed {
		logic       start_cond; // Start condition flag
		logic       wake_req;   // Wake request flag
		logic       reload;     // Reload enabled
		logic       running;    // Counter active
		logic [2:0] clk_sel;    // Selected source
		logic [5:0] count;      // Current count
	} dst_status_type;

endpackage : dst_pkg

// *** rtl/dst_timers.sv ***
// Purpose: Two 6-bit programmable down timers with reload, wake requests and converter gate
// Assumes: Divider taps and auxiliary clock are asynchronous; bus master on CLK_SYS
// Notes:   The bus sequencer only advances while CLK_EN is high; waitrequest keeps its last value while it is low
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`include "dst_timer_defines.svh"
module dst_timers #(
	parameter int TIMERS = 2                       // Fixed pair of timers
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	input  wire logic        CLK_EN,
	input  wire logic        WDT_RESET,
	input  wire logic [15:0] PREDIV_TAPS,
	input  wire logic        AUX_RATE_CLOCK,
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             TIMER_ONE_IRQ,
	output logic             TIMER_TWO_IRQ,
	output logic             HALT_RELEASE,
	output logic             CONVERTER_GATE
);
	import dst_pkg::*;

	// The logic is written for exactly two timers
	if (TIMERS != 2) begin : g_bad_count
		$error("dst_timers supports exactly two timers");
	end

	// Byte enables expanded to a bit mask
	function automatic logic [31:0] lane_mask(input logic [31:0] data, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return data & m;
	endfunction : lane_mask

	// Load word decode; the register form cannot reach bit eight
	function automatic dst_load_type decode_load(input logic [31:0] data);
		dst_load_type w;
		w.clk_sel = data[`DST_LOAD_SEL_MSB:`DST_LOAD_SEL_LSB];
		w.start   = data[`DST_LOAD_VAL_MSB:0];
		if (data[`DST_LOAD_REGFORM_BIT]) begin
			w.clk_sel[2] = 1'b0;
		end
		return w;
	endfunction : decode_load

	// Status word packing
	function automatic logic [31:0] pack_status(input dst_status_type s, input logic [1:0] extra);
		return {17'h0_0000, extra, $bits(dst_status_type)'(s)};
	endfunction : pack_status

	// Synchronised clock sources, indexed by select code
	logic [7:0]  src_raw;                               // Taps in select-code order
	logic [7:0]  src_s1_ff;                             // First synchroniser stage
	logic [7:0]  src_s2_ff;                             // Second synchroniser stage
	logic [7:0]  src_s3_ff;                             // Delayed copy for edge detect
	logic [7:0]  src_rise;                              // One-cycle rising edge per source

	// Timer state, one entry per timer
	logic [5:0]  count_ff      [TIMERS];                // Down counter
	logic [2:0]  sel_ff        [TIMERS];                // Clock select
	logic        run_ff        [TIMERS];                // Counting
	logic        reload_ff     [TIMERS];                // Reload enabled
	logic        uf_seen_ff    [TIMERS];                // Underflow since last load
	logic        wake_req_ff   [TIMERS];                // Wake request one / four
	logic        start_cond_ff [TIMERS];                // Start condition five / six
	logic        irq_en_ff     [TIMERS];                // Interrupt enable one / four
	logic        wake_en_ff    [TIMERS];                // Wake enable one / four
	logic        irq_ff        [TIMERS];                // Registered interrupt outputs

	// Converter gate control
	logic        gate_ff;                               // Converter gate flag
	logic        keep_ff;                               // Keep-gate flag
	logic        conv_mode_ff;                          // Converter mode
	logic        halt_rel_ff;                           // Halt release request

	// Bus slave state
	dst_bus_state_type bus_state_ff;                    // Answer sequencer
	logic        wait_ff;                               // Waitrequest
	logic [31:0] rdata_ff;                              // Read data

	// Per-cycle strobes
	logic        commit;                                // Write takes effect this edge
	logic [31:0] wdata;                                 // Lane-masked write data
	logic        load_stb  [TIMERS];                    // Load instruction
	logic        rl_set    [TIMERS];                    // Reload enable
	logic        rl_clr    [TIMERS];                    // Reload disable
	logic        req_clr   [TIMERS];                    // Clear wake request
	logic        wen_clr   [TIMERS];                    // Wake enable written low
	logic        tick      [TIMERS];                    // Selected source edge
	logic        uf        [TIMERS];                    // Underflow this cycle
	logic        ctl_wr;                                // Control register write
	logic        keep_set;                              // Keep-gate set
	logic        keep_clr;                              // Keep-gate clear
	dst_load_type load_word [TIMERS];                   // Decoded load words

	// Select-code order of the source vector
	assign src_raw = {PREDIV_TAPS[13], PREDIV_TAPS[11], PREDIV_TAPS[7], PREDIV_TAPS[5],
	                  AUX_RATE_CLOCK, PREDIV_TAPS[15], PREDIV_TAPS[3], PREDIV_TAPS[9]};

	// Two-stage synchroniser plus an edge stage; only s2 and s3 feed logic
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			src_s1_ff <= 8'h00;
			src_s2_ff <= 8'h00;
			src_s3_ff <= 8'h00;
		end else if (CLK_EN) begin
			src_s1_ff <= src_raw;
			src_s2_ff <= src_s1_ff;
			src_s3_ff <= src_s2_ff;
		end
	end

	// Rising edge of every source, one count per tap period
	assign src_rise = src_s2_ff & ~src_s3_ff;

	// Write strobes decoded from the committing transfer
	assign commit = (bus_state_ff == DST_BUS_ANSWER) && AVS_WRITE;
	assign wdata  = lane_mask(AVS_WRITEDATA, AVS_BYTEENABLE);
	assign ctl_wr   = commit && (AVS_ADDRESS == `DST_OFF_CONTROL);
	assign keep_set = commit && (AVS_ADDRESS == `DST_OFF_FLAG_SET) && wdata[`DST_FLAG_KEEP_GATE];
	assign keep_clr = commit && (AVS_ADDRESS == `DST_OFF_FLAG_CLR) && wdata[`DST_FLAG_KEEP_GATE];

	// Per-timer strobes and underflow detection
	always_comb begin
		for (int i = 0; i < TIMERS; i++) begin
			load_word[i] = decode_load(wdata);
			load_stb[i]  = commit && (AVS_ADDRESS == ((i == 0) ? `DST_OFF_LOAD_ONE : `DST_OFF_LOAD_TWO));
			rl_set[i]    = commit && (AVS_ADDRESS == `DST_OFF_FLAG_SET) && wdata[i];
			rl_clr[i]    = commit && (AVS_ADDRESS == `DST_OFF_FLAG_CLR) && wdata[i];
			req_clr[i]   = commit && (AVS_ADDRESS == `DST_OFF_CLEAR_REQ) && wdata[i];
			wen_clr[i]   = ctl_wr && !wdata[`DST_CTL_WAKE_EN_ONE + i];
			tick[i]      = src_rise[sel_ff[i]];
			uf[i]        = run_ff[i] && tick[i] && (count_ff[i] == 6'h00);
		end
	end

	// Counters, clock selects and run control
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			sel_ff[0] <= `DST_RST_SEL_ONE;
			sel_ff[1] <= `DST_RST_SEL_TWO;
			for (int i = 0; i < TIMERS; i++) begin
				count_ff[i]   <= `DST_COUNT_TOP;
				run_ff[i]     <= 1'b0;
				uf_seen_ff[i] <= 1'b0;
			end
		end else if (CLK_EN) begin
			for (int i = 0; i < TIMERS; i++) begin
				if (WDT_RESET) begin
					// Clock selection is left alone here
					count_ff[i]   <= `DST_COUNT_TOP;
					run_ff[i]     <= 1'b0;
					uf_seen_ff[i] <= 1'b0;
				end else if (load_stb[i]) begin
					// Load restarts at once from the new value
					count_ff[i]   <= load_word[i].start;
					sel_ff[i]     <= load_word[i].clk_sel;
					run_ff[i]     <= 1'b1;
					uf_seen_ff[i] <= 1'b0;
				end else begin
					if (run_ff[i] && tick[i]) begin
						// Zero wraps to 3Fh through plain 6-bit decrement
						count_ff[i] <= count_ff[i] - 6'h01;
					end
					if (uf[i]) begin
						uf_seen_ff[i] <= 1'b1;
						if (!reload_ff[i]) begin
							run_ff[i] <= 1'b0;
						end
					end
					if (rl_set[i]) begin
						// Runs from whatever count is held
						run_ff[i] <= 1'b1;
					end else if (rl_clr[i] && (uf_seen_ff[i] || uf[i])) begin
						// No reload after an underflow: halt now
						run_ff[i] <= 1'b0;
					end
				end
			end
		end
	end

	// Reload enables; set and clear never coincide in one write
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < TIMERS; i++) begin
				reload_ff[i] <= 1'b0;
			end
		end else if (CLK_EN) begin
			for (int i = 0; i < TIMERS; i++) begin
				if (WDT_RESET || rl_clr[i]) begin
					reload_ff[i] <= 1'b0;
				end else if (rl_set[i]) begin
					reload_ff[i] <= 1'b1;
				end
			end
		end
	end

	// Wake requests: an underflow wins over a clear in the same cycle
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < TIMERS; i++) begin
				wake_req_ff[i] <= 1'b0;
			end
		end else if (CLK_EN) begin
			for (int i = 0; i < TIMERS; i++) begin
				if (WDT_RESET) begin
					wake_req_ff[i] <= 1'b0;
				end else if (uf[i]) begin
					wake_req_ff[i] <= 1'b1;
				end else if (req_clr[i]) begin
					wake_req_ff[i] <= 1'b0;
				end
			end
		end
	end

	// Enables and converter mode from the control register
	always_ff @(posedge CLK_SYS) begin
		if (RESET || (CLK_EN && WDT_RESET)) begin
			for (int i = 0; i < TIMERS; i++) begin
				irq_en_ff[i]  <= 1'b0;
				wake_en_ff[i] <= 1'b0;
			end
			conv_mode_ff <= 1'b0;
		end else if (CLK_EN && ctl_wr) begin
			for (int i = 0; i < TIMERS; i++) begin
				irq_en_ff[i]  <= wdata[`DST_CTL_IRQ_EN_ONE + i];
				wake_en_ff[i] <= wdata[`DST_CTL_WAKE_EN_ONE + i];
			end
			conv_mode_ff <= wdata[`DST_CTL_CONV_MODE];
		end
	end

	// Start condition flags; a fresh underflow outlasts a request clear but not a wake enable written low
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < TIMERS; i++) begin
				start_cond_ff[i] <= 1'b0;
			end
		end else if (CLK_EN) begin
			for (int i = 0; i < TIMERS; i++) begin
				if (WDT_RESET) begin
					start_cond_ff[i] <= 1'b0;
				end else if ((req_clr[i] && !uf[i]) || wen_clr[i]) begin
					start_cond_ff[i] <= 1'b0;
				end else if (wake_req_ff[i] && !irq_en_ff[i] && wake_en_ff[i]) begin
					start_cond_ff[i] <= 1'b1;
				end
			end
		end
	end

	// Interrupt and halt release outputs, registered
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < TIMERS; i++) begin
				irq_ff[i] <= 1'b0;
			end
			halt_rel_ff <= 1'b0;
		end else if (CLK_EN) begin
			if (WDT_RESET) begin
				// Watchdog drops the outputs at once, as power-on reset does
				for (int i = 0; i < TIMERS; i++) begin
					irq_ff[i] <= 1'b0;
				end
				halt_rel_ff <= 1'b0;
			end else begin
				irq_ff[0]   <= wake_req_ff[0] && irq_en_ff[0];
				irq_ff[1]   <= wake_req_ff[1] && irq_en_ff[1];
				halt_rel_ff <= (wake_req_ff[0] && !irq_en_ff[0] && wake_en_ff[0]) ||
				               (wake_req_ff[1] && !irq_en_ff[1] && wake_en_ff[1]);
			end
		end
	end

	// Keep-gate flag
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			keep_ff <= 1'b0;
		end else if (CLK_EN) begin
			if (WDT_RESET || keep_clr) begin
				keep_ff <= 1'b0;
			end else if (keep_set) begin
				keep_ff <= 1'b1;
			end
		end
	end

	// Converter gate: opens on a converter-mode timer two load, closes on timer two underflow unless keep-gate is set
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			gate_ff <= 1'b0;
		end else if (CLK_EN) begin
			if (WDT_RESET) begin
				gate_ff <= 1'b0;
			end else if (load_stb[1] && conv_mode_ff) begin
				gate_ff <= 1'b1;
			end else if (uf[1] && !keep_ff) begin
				// Closing on the underflow itself gives an exact window
				gate_ff <= 1'b0;
			end
		end
	end

	// Bus sequencer: one idle cycle to fetch, one answer cycle to commit
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			bus_state_ff <= DST_BUS_IDLE;
			wait_ff      <= 1'b1;
			rdata_ff     <= 32'h0000_0000;
		end else if (CLK_EN && WDT_RESET) begin
			// Watchdog abandons a pending request; no answer is given
			bus_state_ff <= DST_BUS_IDLE;
			wait_ff      <= 1'b1;
		end else if (CLK_EN) begin
			case (bus_state_ff)
				DST_BUS_IDLE: begin
					if (AVS_READ || AVS_WRITE) begin
						bus_state_ff <= DST_BUS_ANSWER;
						wait_ff      <= 1'b0;
						// Only a read reloads the data, so a write leaves the last read standing
						if (AVS_READ) begin
							case (AVS_ADDRESS)
								`DST_OFF_FLAG_SET,
								`DST_OFF_FLAG_CLR: begin
									rdata_ff <= {29'h0000_0000, keep_ff, reload_ff[1], reload_ff[0]};
								end
								`DST_OFF_CONTROL: begin
									rdata_ff <= {27'h000_0000, conv_mode_ff, wake_en_ff[1], wake_en_ff[0],
									             irq_en_ff[1], irq_en_ff[0]};
								end
								`DST_OFF_STATUS_ONE: begin
									rdata_ff <= pack_status({start_cond_ff[0], wake_req_ff[0], reload_ff[0],
									                         run_ff[0], sel_ff[0], count_ff[0]}, 2'h0);
								end
								`DST_OFF_STATUS_TWO: begin
									rdata_ff <= pack_status({start_cond_ff[1], wake_req_ff[1], reload_ff[1],
									                         run_ff[1], sel_ff[1], count_ff[1]},
									                        {keep_ff, gate_ff});
								end
								default: begin
									// Write-only and unmapped words read zero
									rdata_ff <= 32'h0000_0000;
								end
							endcase
						end
					end
				end
				DST_BUS_ANSWER: begin
					bus_state_ff <= DST_BUS_IDLE;
					wait_ff      <= 1'b1;
				end
				default: begin
					bus_state_ff <= DST_BUS_IDLE;
					wait_ff      <= 1'b1;
				end
			endcase
		end
	end

	// Outputs straight from flip-flops
	assign AVS_READDATA    = rdata_ff;
	assign AVS_WAITREQUEST = wait_ff;
	assign TIMER_ONE_IRQ   = irq_ff[0];
	assign TIMER_TWO_IRQ   = irq_ff[1];
	assign HALT_RELEASE    = halt_rel_ff;
	assign CONVERTER_GATE  = gate_ff;

endmodule : dst_timers

// *** tb/dst_timers_sva.sv ***
// Purpose: Port-level checks for the dual down timers
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Sees only the top-level ports; bound from the bench top
`timescale 1ns/1ns
`include "dst_timer_defines.svh"
module dst_timers_sva #(
	parameter int TIMERS = 2 // Same fixed pair as the design
) (
	input wire logic        CLK_SYS,
	input wire logic        RESET,
	input wire logic        CLK_EN,
	input wire logic        WDT_RESET,
	input wire logic [15:0] PREDIV_TAPS,
	input wire logic        AUX_RATE_CLOCK,
	input wire logic [5:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        TIMER_ONE_IRQ,
	input wire logic        TIMER_TWO_IRQ,
	input wire logic        HALT_RELEASE,
	input wire logic        CONVERTER_GATE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	// Request seen by an idle sequencer
	sequence s_taken;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CLK_EN && !WDT_RESET;
	endsequence
	// No write or watchdog could have touched the flags last cycle
	sequence s_quiet;
		!$past(AVS_WRITE) && !$past(WDT_RESET) && !WDT_RESET && CLK_EN;
	endsequence
	// Outputs in their reset state
	sequence s_cleared;
		AVS_WAITREQUEST && !TIMER_ONE_IRQ && !TIMER_TWO_IRQ && !HALT_RELEASE && !CONVERTER_GATE;
	endsequence

	a_bus_answer_once: assert property (s_taken |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus answer not exactly one cycle");
	a_wait_idle: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer without a request");
	a_reset_quiet: assert property ($fell(RESET) |-> s_cleared)
		else $error("outputs not cleared by reset");
	a_wdt_quiet: assert property (WDT_RESET && CLK_EN |=> s_cleared)
		else $error("outputs not cleared by watchdog");
	a_gate_cause: assert property ($rose(CONVERTER_GATE) |->
		$past(AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `DST_OFF_LOAD_TWO))
		else $error("gate opened without a timer two load");
	a_unmapped_zero: assert property (s_taken ##0 AVS_READ && AVS_ADDRESS[5] |=> AVS_READDATA == 32'h00000000)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (!(AVS_READ && AVS_WAITREQUEST) && !WDT_RESET |=> $stable(AVS_READDATA))
		else $error("read data changed without a read");
	a_irq_one_holds: assert property (TIMER_ONE_IRQ ##0 s_quiet |=> TIMER_ONE_IRQ)
		else $error("timer one interrupt dropped on its own");
	a_irq_two_holds: assert property (TIMER_TWO_IRQ ##0 s_quiet |=> TIMER_TWO_IRQ)
		else $error("timer two interrupt dropped on its own");
	a_halt_holds: assert property (HALT_RELEASE ##0 s_quiet |=> HALT_RELEASE)
		else $error("halt release dropped on its own");
endmodule : dst_timers_sva

// *** tb/dst_timers_test.sv ***
// Purpose: Self-checking bench for the dual down timers
// Assumes: Free-running divider and auxiliary clock made here
// Notes:   Byte enables held on; clock enable dropped in one freeze scenario
`timescale 1ns/1ns
`include "dst_timer_defines.svh"
module dst_timers_test;
	import dst_pkg::*;
	logic        clk_sys   = 1'b0;    // 50 MHz system clock
	logic        reset     = 1'b1;    // Power-on reset
	logic        wdt_reset = 1'b0;    // Watchdog reset pulse
	logic        clk_en    = 1'b1;    // Clock enable, dropped once
	logic        aux_clk   = 1'b0;    // Auxiliary clock, period 10 cycles
	logic [15:0] div_ff    = 16'h0000; // Pre-divider, bit n-1 is stage n
	logic [3:0]  aux_ff    = 4'h0;    // Auxiliary half-period count
	logic [5:0]  address   = 6'h00;   // Bus address
	logic        rd_req    = 1'b0;    // Bus read
	logic        wr_req    = 1'b0;    // Bus write
	logic [31:0] wdata     = 32'h00000000;
	logic [31:0] q;                   // Last read data
	wire  [31:0] rdata;
	wire         waitreq, irq_one, irq_two, halt_rel, gate;
	wire  [2:0]  evt       = {halt_rel, irq_two, irq_one};
	int          n_fail    = 0;
	int          cmp_count = 0;
	int          el;                  // Cycles waited for an event
	int          per[8]    = '{512, 8, 32768, 10, 32, 128, 2048, 8192}; // Count length per select code

	dst_timers dut (.CLK_SYS(clk_sys), .RESET(reset), .CLK_EN(clk_en), .WDT_RESET(wdt_reset),
		.PREDIV_TAPS({div_ff[14:0], 1'b0}), .AUX_RATE_CLOCK(aux_clk), .AVS_ADDRESS(address),
		.AVS_READ(rd_req), .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .TIMER_ONE_IRQ(irq_one),
		.TIMER_TWO_IRQ(irq_two), .HALT_RELEASE(halt_rel), .CONVERTER_GATE(gate));

	// Clock, half period 10 ns
	always #10 clk_sys = ~clk_sys;

	// Divider taps and auxiliary clock, driven on the rising edge
	always @(posedge clk_sys) begin
		div_ff <= div_ff + 16'h0001;
		aux_ff <= (aux_ff == 4'h4) ? 4'h0 : aux_ff + 4'h1;
		if (aux_ff == 4'h4) begin
			aux_clk <= ~aux_clk;
		end
	end

	// Verdict and end of run
	task results;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One Avalon transfer; held until waitrequest is sampled low
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		address <= a;
		wdata <= d;
		wr_req <= wr;
		rd_req <= !wr;
		// Waits however long the answer takes; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (waitreq !== 1'b0);
		q = rdata;
		wr_req <= 1'b0;
		rd_req <= 1'b0;
	endtask : bus

	// Bounded wait for an event line
	task wt(input int t, input int lim);
		el = 0;
		while (evt[t] !== 1'b1 && el < lim) begin
			@(posedge clk_sys);
			el++;
		end
	endtask : wt

	// Clear a wake request and see its interrupt fall
	task clr(input int t);
		bus(1'b1, `DST_OFF_CLEAR_REQ, 32'h1 << t);
		repeat (2) @(posedge clk_sys);
		chk(evt[t], 1'b0);
	endtask : clr

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		bus(1'b0, `DST_OFF_STATUS_ONE, 0); chk(q, 32'h0000007F);
		bus(1'b0, `DST_OFF_STATUS_TWO, 0); chk(q, 32'h0000017F);
		bus(1'b0, 6'h20, 0); chk(q, 32'h00000000);
		// Every select code, start value 1: two counts to underflow
		bus(1'b1, `DST_OFF_CONTROL, 32'h3);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, i[0] ? `DST_OFF_LOAD_TWO : `DST_OFF_LOAD_ONE, {23'h0, i[2:0], 6'h01});
			wt(i[0], 2 * per[i] + 20);
			chk(el > per[i] && el <= 2 * per[i] + 8, 1'b1);
			bus(1'b0, i[0] ? `DST_OFF_STATUS_TWO : `DST_OFF_STATUS_ONE, 0);
			chk(q, 32'h800 | (i << 6) | 32'h3F);
			clr(i[0]);
		end
		// Halt release with interrupts off, then start flag cleared
		for (int t = 0; t < 2; t++) begin
			bus(1'b1, `DST_OFF_CONTROL, 32'h4 << t);
			bus(1'b1, t ? `DST_OFF_LOAD_TWO : `DST_OFF_LOAD_ONE, 32'h40);
			wt(2, 40);
			chk(evt, 3'b100);
			bus(1'b0, t ? `DST_OFF_STATUS_TWO : `DST_OFF_STATUS_ONE, 0); chk(q[12:11], 2'b11);
			bus(1'b1, `DST_OFF_CONTROL, 0);
			bus(1'b0, t ? `DST_OFF_STATUS_TWO : `DST_OFF_STATUS_ONE, 0); chk(q[12:11], 2'b01);
			bus(1'b1, `DST_OFF_CLEAR_REQ, 32'h1 << t);
		end
		// Timer one reload: wraps to a full 64-count period, stops on disable
		bus(1'b1, `DST_OFF_CONTROL, 32'h1);
		bus(1'b1, `DST_OFF_LOAD_ONE, 32'h41);
		bus(1'b1, `DST_OFF_FLAG_SET, 32'h1);
		bus(1'b0, `DST_OFF_FLAG_SET, 0); chk(q[2:0], 3'h1);
		wt(0, 40); chk(el < 40, 1'b1);
		clr(0);
		wt(0, 600); chk(el > 480 && el <= 520, 1'b1);
		bus(1'b1, `DST_OFF_FLAG_CLR, 32'h1);
		bus(1'b0, `DST_OFF_STATUS_ONE, 0); chk(q[10:9], 2'b00);
		clr(0);
		wt(0, 600); chk(el, 600);
		// Timer two converter gate held by keep-gate, closed on last underflow
		bus(1'b1, `DST_OFF_CONTROL, 32'h12);
		bus(1'b1, `DST_OFF_LOAD_TWO, 32'h41);
		@(posedge clk_sys); chk(gate, 1'b1);
		bus(1'b1, `DST_OFF_FLAG_SET, 32'h6);
		wt(1, 40); chk(gate, 1'b1);
		clr(1);
		bus(1'b1, `DST_OFF_FLAG_CLR, 32'h4);
		wt(1, 600); chk(gate, 1'b0);
		bus(1'b1, `DST_OFF_FLAG_CLR, 32'h2);
		bus(1'b0, `DST_OFF_STATUS_TWO, 0); chk(q[14:9], 6'h04);
		// Register form forces bit 8 low; watchdog keeps selections
		bus(1'b1, `DST_OFF_LOAD_ONE, 32'h101C0);
		bus(1'b1, `DST_OFF_LOAD_TWO, 32'h1C0);
		@(posedge clk_sys);
		wdt_reset <= 1'b1;
		@(posedge clk_sys);
		wdt_reset <= 1'b0;
		bus(1'b0, `DST_OFF_STATUS_ONE, 0); chk(q[8:6], 3'h3);
		bus(1'b0, `DST_OFF_STATUS_TWO, 0); chk(q[8:6], 3'h7);
		bus(1'b0, `DST_OFF_CONTROL, 0); chk(q, 32'h00000000);
		// Clock enable low freezes a timer that is one tick from underflow
		bus(1'b1, `DST_OFF_CONTROL, 32'h1);
		bus(1'b1, `DST_OFF_LOAD_ONE, 32'h40);
		clk_en <= 1'b0;
		repeat (40) @(posedge clk_sys);
		chk(irq_one, 1'b0);
		clk_en <= 1'b1;
		wt(0, 40); chk(el < 40, 1'b1);
		results();
	end

	// Watchdog against a hang, above the expected run length
	initial begin
		repeat (99000) @(posedge clk_sys);
		n_fail++;
		results();
	end
endmodule : dst_timers_test

bind dst_timers dst_timers_sva #(.TIMERS(TIMERS)) u_sva (.CLK_SYS(CLK_SYS), .RESET(RESET), .CLK_EN(CLK_EN),
	.WDT_RESET(WDT_RESET), .PREDIV_TAPS(PREDIV_TAPS), .AUX_RATE_CLOCK(AUX_RATE_CLOCK),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.TIMER_ONE_IRQ(TIMER_ONE_IRQ), .TIMER_TWO_IRQ(TIMER_TWO_IRQ), .HALT_RELEASE(HALT_RELEASE),
	.CONVERTER_GATE(CONVERTER_GATE));
